// ### include/adcr_consts.vh
/*
 * Offsets, fields, reset values and frame sizes of the register bank.
 * Assumes inclusion by bare name.
 */
`ifndef ADCR_CONSTS_VH
`define ADCR_CONSTS_VH

// Register offsets (13-bit address space)
`define ADCR_OFS_PORT_SETUP     13'h0000
`define ADCR_OFS_PART_ID        13'h0001
`define ADCR_OFS_GRADE_ID       13'h0002
`define ADCR_OFS_POWER_STATE    13'h0008
`define ADCR_OFS_LOOP_ENABLE    13'h0009
`define ADCR_OFS_LOOP_CONTROL   13'h000a
`define ADCR_OFS_INPUT_BW       13'h000f
`define ADCR_OFS_OUTPUT_MODE    13'h0014
`define ADCR_OFS_OUTPUT_DRIVE   13'h0015
`define ADCR_OFS_OUT_CLK_CTRL   13'h0016
`define ADCR_OFS_REF_SELECT     13'h0018
`define ADCR_OFS_OUTPUT_RATE    13'h0101
`define ADCR_OFS_RANGE_CTRL     13'h0111

// Field positions
`define ADCR_BIT_ORDER_HI       6
`define ADCR_BIT_ORDER_LO       1
`define ADCR_BIT_RESTORE_HI     5
`define ADCR_BIT_RESTORE_LO     2
`define ADCR_PORT_FIXED_ONES    8'h18
`define ADCR_BIT_LOOP_ON        2
`define ADCR_BIT_LOCK           7
`define ADCR_BIT_AUTO_BAND      6
`define ADCR_BIT_LEVEL_SEL      7
`define ADCR_BIT_INTERLEAVE     5
`define ADCR_BIT_TRISTATE       4
`define ADCR_BIT_POL_FLIP       2
`define ADCR_BIT_CLK_INVERT     7
`define ADCR_BIT_EXT_REF        6
`define ADCR_BIT_FILT_RST_FLAG  7
`define ADCR_BIT_RANGE_MODE     6

// Writable masks per register
`define ADCR_MASK_POWER_STATE   8'h03
`define ADCR_MASK_LOOP_ENABLE   8'h04
`define ADCR_MASK_LOOP_CONTROL  8'h7f
`define ADCR_MASK_INPUT_BW      8'h60
`define ADCR_MASK_OUTPUT_MODE   8'hb7
`define ADCR_MASK_OUTPUT_DRIVE  8'h0f
`define ADCR_MASK_OUT_CLK_CTRL  8'h80
`define ADCR_MASK_REF_SELECT    8'h40
`define ADCR_MASK_OUTPUT_RATE   8'h3f
`define ADCR_MASK_RANGE_CTRL    8'hff

// Reset values
`define ADCR_RST_ZERO           8'h00
`define ADCR_RST_OUTPUT_DRIVE   8'h02

// Power states
`define ADCR_PWR_NORMAL         2'h0
`define ADCR_PWR_LOCAL_DOWN     2'h1
`define ADCR_PWR_STANDBY        2'h2
`define ADCR_PWR_SLEEP          2'h3

// Frame layout: 16-bit instruction, then 8-bit words
`define ADCR_INSTR_BITS         5'h10
`define ADCR_WORD_BITS          4'h8

`endif

// ### src/adcr_link_sync.v
/*
 * Two-flop synchroniser and edge finder for the serial pins.
 * Assumes pins asynchronous to the reference clock.
 */
`timescale 1ns/1ps
`default_nettype none

module adcr_link_sync (
    input  wire       clk_i,
    input  wire       nrst_i,
    input  wire       sclk_i,
    input  wire       sel_n_i,
    input  wire       sdi_i,
    output wire       sclk_rise_o,
    output wire       sclk_fall_o,
    output wire       sel_n_o,
    output wire       sdi_o
);

    reg [1:0] sclk_meta;
    reg [1:0] sel_meta;
    reg [1:0] sdi_meta;
    reg       sclk_last;

    ////////////////////////////////////////////////////////////////////////
    // Two flops per pin, then one more for edge finding
    always @(posedge clk_i) begin
        if (!nrst_i) begin
            sclk_meta <= 2'h0;
            sel_meta  <= 2'h3;
            sdi_meta  <= 2'h0;
            sclk_last <= 1'b0;
        end else begin
            sclk_meta <= {sclk_meta[0], sclk_i};
            sel_meta  <= {sel_meta[0], sel_n_i};
            sdi_meta  <= {sdi_meta[0], sdi_i};
            sclk_last <= sclk_meta[1];
        end
    end

    // Edge pulses from the second stage only
    assign sclk_rise_o = sclk_meta[1] & ~sclk_last;
    assign sclk_fall_o = ~sclk_meta[1] & sclk_last;
    assign sel_n_o     = sel_meta[1];
    assign sdi_o       = sdi_meta[1];

endmodule

`default_nettype wire

// ### src/adcr_reg_bank.v
/*
 * Configuration and status register bank reached over a three-wire
 * serial port, plus the output-path controls it steers.
 * Assumes REF_CLK_I at least 4x the serial clock, select active low.
 */
// Operation
// - Mirrored bits 6 and 1 set bit order; 1 means LSB first.
// - Restore bits 5/2 default all but 0x00, 0x09, 0x0A.
// - Two-bit power state: normal, local down, standby, sleep.
// - Loop control bit 6 enables auto band, default off.
// - Loop control bit 7 shows multiplier lock.
// - Output mode bit 5 interleaves both channels.
// - Output mode bit 4 tristates the data outputs.
// - Output mode bit 2 inverts the output data.
// - Reference bit 6 picks external reference.
// - Six-bit rate divisor, resets to zero.
// - Overrange bit 7 shows filter resets on the flag.
// - 16-bit instruction, then 8-bit words.
// - Threshold mode: flag high when the selected sample, before inversion, exceeds threshold.
// - MSB first after power-up.
`timescale 1ns/1ps
`default_nettype none
`include "adcr_consts.vh"

module adcr_reg_bank #(
    parameter [7:0] PART_ID  = 8'h5a,   // Arbitrary value
    parameter [1:0] GRADE_ID = 2'h1     // Arbitrary value
) (
    input  wire        REF_CLK_I,
    input  wire        NRST_I,
    input  wire        SCLK_I,
    input  wire        SELECT_N_I,
    input  wire        SDIO_I,
    output reg         SDIO_O,
    output reg         SDIO_OE_N_O,
    input  wire        LOCK_I,
    input  wire        FILTER_RESET_I,
    input  wire [15:0] CHAN_A_I,
    input  wire [15:0] CHAN_B_I,
    input  wire        SAMPLE_STB_I,
    output reg  [15:0] DATA_O,
    output wire [15:0] DATA_OE_N_O,
    output reg         RANGE_FLAG_O,
    output wire [1:0]  POWER_STATE_SELECT_O,
    output wire        MULTIPLIER_LOOP_ON_O,
    output wire        AUTO_BAND_SELECT_O,
    output wire [5:0]  MULTIPLIER_RATIO_O,
    output wire [1:0]  BANDWIDTH_SELECT_O,
    output wire        OUTPUT_LEVEL_SELECT_O,
    output wire [1:0]  DATA_FORMAT_O,
    output wire [1:0]  DRIVE_STRENGTH_HIGH_VOLT_O,
    output wire [1:0]  DRIVE_STRENGTH_LOW_VOLT_O,
    output wire        SAMPLE_CLOCK_OUT_INVERT_O,
    output wire        EXTERNAL_REF_SELECT_O,
    output wire [5:0]  OUTPUT_RATE_DIV_O
);

    // Frame states
    localparam [2:0] ST_INSTR = 3'h1;
    localparam [2:0] ST_WRITE = 3'h2;
    localparam [2:0] ST_READ  = 3'h4;

    wire       sclk_rise;
    wire       sclk_fall;
    wire       sel_n;
    wire       sdi;

    reg        bit_order_reverse;
    reg [7:0]  power_state;
    reg [7:0]  loop_enable;
    reg [7:0]  loop_control;
    reg [7:0]  input_bw;
    reg [7:0]  output_mode;
    reg [7:0]  output_drive;
    reg [7:0]  out_clk_ctrl;
    reg [7:0]  ref_select;
    reg [7:0]  output_rate;
    reg [7:0]  range_ctrl;

    reg [2:0]  state;
    reg [15:0] instr;
    reg [4:0]  bit_cnt;
    reg [7:0]  shift;
    reg [12:0] addr;
    reg        is_read;
    reg        chan_sel;
    reg [1:0]  lock_sync;
    reg [1:0]  filt_sync;
    reg        write_done;
    reg [12:0] last_addr;

    ////////////////////////////////////////////////////////////////////////
    // Link pin synchroniser
    adcr_link_sync u_sync (
        .clk_i       (REF_CLK_I),
        .nrst_i      (NRST_I),
        .sclk_i      (SCLK_I),
        .sel_n_i     (SELECT_N_I),
        .sdi_i       (SDIO_I),
        .sclk_rise_o (sclk_rise),
        .sclk_fall_o (sclk_fall),
        .sel_n_o     (sel_n),
        .sdi_o       (sdi)
    );

    // Read data multiplexer over the register map
    function [7:0] read_mux;
        input [12:0] a;
        begin
            case (a)
                `ADCR_OFS_PORT_SETUP:   read_mux = `ADCR_PORT_FIXED_ONES |
                    ({7'h00, bit_order_reverse} << `ADCR_BIT_ORDER_HI) |
                    ({7'h00, bit_order_reverse} << `ADCR_BIT_ORDER_LO);
                `ADCR_OFS_PART_ID:      read_mux = PART_ID;
                `ADCR_OFS_GRADE_ID:     read_mux = {2'h0, GRADE_ID, 4'h0};
                `ADCR_OFS_POWER_STATE:  read_mux = power_state;
                `ADCR_OFS_LOOP_ENABLE:  read_mux = loop_enable;
                `ADCR_OFS_LOOP_CONTROL: read_mux = loop_control |
                    ({7'h00, lock_sync[1]} << `ADCR_BIT_LOCK);
                `ADCR_OFS_INPUT_BW:     read_mux = input_bw;
                `ADCR_OFS_OUTPUT_MODE:  read_mux = output_mode;
                `ADCR_OFS_OUTPUT_DRIVE: read_mux = output_drive;
                `ADCR_OFS_OUT_CLK_CTRL: read_mux = out_clk_ctrl;
                `ADCR_OFS_REF_SELECT:   read_mux = ref_select;
                `ADCR_OFS_OUTPUT_RATE:  read_mux = output_rate;
                `ADCR_OFS_RANGE_CTRL:   read_mux = range_ctrl;
                default:                read_mux = 8'h00;
            endcase
        end
    endfunction

    // Next serial bit index, honouring bit order
    function [2:0] bit_pos;
        input [3:0] n;
        input       lsb_first;
        begin
            bit_pos = lsb_first ? n[2:0] : (3'h7 - n[2:0]);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Status inputs from other domains
    always @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            lock_sync <= 2'h0;
            filt_sync <= 2'h0;
        end else begin
            lock_sync <= {lock_sync[0], LOCK_I};
            filt_sync <= {filt_sync[0], FILTER_RESET_I};
        end
    end

    wire       restore = (last_addr == `ADCR_OFS_PORT_SETUP) &&
                         (shift[`ADCR_BIT_RESTORE_HI] | shift[`ADCR_BIT_RESTORE_LO]);
    wire [7:0] read_byte = read_mux(addr);

    ////////////////////////////////////////////////////////////////////////
    // Serial frame engine and register writes
    always @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            state             <= ST_INSTR;
            instr             <= 16'h0000;
            bit_cnt           <= 5'h00;
            shift             <= 8'h00;
            addr              <= 13'h0000;
            is_read           <= 1'b0;
            SDIO_O            <= 1'b0;
            SDIO_OE_N_O       <= 1'b1;
            bit_order_reverse <= 1'b0;
            power_state       <= `ADCR_RST_ZERO;
            loop_enable       <= `ADCR_RST_ZERO;
            loop_control      <= `ADCR_RST_ZERO;
            input_bw          <= `ADCR_RST_ZERO;
            output_mode       <= `ADCR_RST_ZERO;
            output_drive      <= `ADCR_RST_OUTPUT_DRIVE;
            out_clk_ctrl      <= `ADCR_RST_ZERO;
            ref_select        <= `ADCR_RST_ZERO;
            output_rate       <= `ADCR_RST_ZERO;
            range_ctrl        <= `ADCR_RST_ZERO;
        end else if (sel_n) begin
            // Idle between frames: release the data pin
            state       <= ST_INSTR;
            bit_cnt     <= 5'h00;
            SDIO_OE_N_O <= 1'b1;
        end else if (sclk_rise && state == ST_INSTR) begin
            instr   <= bit_order_reverse ? {sdi, instr[15:1]} : {instr[14:0], sdi};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `ADCR_INSTR_BITS - 5'h01) begin
                bit_cnt <= 5'h00;
                if (bit_order_reverse) begin
                    is_read <= sdi;
                    addr    <= instr[13:1];
                end else begin
                    is_read <= instr[14];
                    addr    <= {instr[11:0], sdi};
                end
                state <= (bit_order_reverse ? sdi : instr[14]) ? ST_READ : ST_WRITE;
            end
        end else if (sclk_rise && state == ST_WRITE) begin
            shift[bit_pos(bit_cnt[3:0], bit_order_reverse)] <= sdi;
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt[3:0] == `ADCR_WORD_BITS - 4'h1) begin
                bit_cnt <= 5'h00;
                addr    <= bit_order_reverse ? addr + 13'h0001 : addr - 13'h0001;
            end
        end else if (sclk_fall && state == ST_READ) begin
            // Readback: drive on falling edge, advance per word
            SDIO_OE_N_O <= 1'b0;
            SDIO_O      <= read_byte[bit_pos(bit_cnt[3:0], bit_order_reverse)];
            bit_cnt     <= bit_cnt + 5'h01;
            if (bit_cnt[3:0] == `ADCR_WORD_BITS - 4'h1) begin
                bit_cnt <= 5'h00;
                addr    <= bit_order_reverse ? addr + 13'h0001 : addr - 13'h0001;
            end
        end
        // Commit a completed write word one cycle after its last bit
        if (NRST_I && !sel_n && state == ST_WRITE && write_done) begin
            if (restore) begin
                power_state  <= `ADCR_RST_ZERO;
                input_bw     <= `ADCR_RST_ZERO;
                output_mode  <= `ADCR_RST_ZERO;
                output_drive <= `ADCR_RST_OUTPUT_DRIVE;
                out_clk_ctrl <= `ADCR_RST_ZERO;
                ref_select   <= `ADCR_RST_ZERO;
                output_rate  <= `ADCR_RST_ZERO;
                range_ctrl   <= `ADCR_RST_ZERO;
            end
            case (last_addr)
                // either mirror bit sets the order
                `ADCR_OFS_PORT_SETUP:   bit_order_reverse <=
                    shift[`ADCR_BIT_ORDER_HI] | shift[`ADCR_BIT_ORDER_LO];
                `ADCR_OFS_POWER_STATE:  power_state  <= shift & `ADCR_MASK_POWER_STATE;
                `ADCR_OFS_LOOP_ENABLE:  loop_enable  <= shift & `ADCR_MASK_LOOP_ENABLE;
                // auto band and ratio writable, lock bit not
                `ADCR_OFS_LOOP_CONTROL: loop_control <= shift & `ADCR_MASK_LOOP_CONTROL;
                `ADCR_OFS_INPUT_BW:     input_bw     <= shift & `ADCR_MASK_INPUT_BW;
                `ADCR_OFS_OUTPUT_MODE:  output_mode  <= shift & `ADCR_MASK_OUTPUT_MODE;
                `ADCR_OFS_OUTPUT_DRIVE: output_drive <= shift & `ADCR_MASK_OUTPUT_DRIVE;
                `ADCR_OFS_OUT_CLK_CTRL: out_clk_ctrl <= shift & `ADCR_MASK_OUT_CLK_CTRL;
                `ADCR_OFS_REF_SELECT:   ref_select   <= shift & `ADCR_MASK_REF_SELECT;
                `ADCR_OFS_OUTPUT_RATE:  output_rate  <= shift & `ADCR_MASK_OUTPUT_RATE;
                `ADCR_OFS_RANGE_CTRL:   range_ctrl   <= shift & `ADCR_MASK_RANGE_CTRL;
                default:                ;
            endcase
        end
    end

    // Word-complete marker and the address it was written to
    always @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            write_done <= 1'b0;
            last_addr  <= 13'h0000;
        end else begin
            write_done <= !sel_n && sclk_rise && state == ST_WRITE &&
                          bit_cnt[3:0] == `ADCR_WORD_BITS - 4'h1;
            last_addr  <= addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output data path: interleave, inversion, tristate
    wire [15:0] sample = (output_mode[`ADCR_BIT_INTERLEAVE] && chan_sel) ? CHAN_B_I : CHAN_A_I;
    wire [5:0]  thresh = range_ctrl[5:0];

    always @(posedge REF_CLK_I) begin
        if (!NRST_I) begin
            DATA_O       <= 16'h0000;
            chan_sel     <= 1'b0;
            RANGE_FLAG_O <= 1'b0;
        end else begin
            if (SAMPLE_STB_I) begin
                chan_sel <= output_mode[`ADCR_BIT_INTERLEAVE] ? ~chan_sel : 1'b0;
                DATA_O   <= output_mode[`ADCR_BIT_POL_FLIP] ? ~sample : sample;
                // threshold compare on the 16-bit selected sample, before inversion
                RANGE_FLAG_O <= (sample > {thresh, 10'h000}) ||
                    (range_ctrl[`ADCR_BIT_FILT_RST_FLAG] & filt_sync[1]);
            end
        end
    end

    assign DATA_OE_N_O = {16{output_mode[`ADCR_BIT_TRISTATE]}};

    ////////////////////////////////////////////////////////////////////////
    // Control fields to the rest of the converter
    assign POWER_STATE_SELECT_O       = power_state[1:0];
    assign MULTIPLIER_LOOP_ON_O       = loop_enable[`ADCR_BIT_LOOP_ON];
    assign AUTO_BAND_SELECT_O         = loop_control[`ADCR_BIT_AUTO_BAND];
    assign MULTIPLIER_RATIO_O         = loop_control[5:0];
    assign BANDWIDTH_SELECT_O         = input_bw[6:5];
    assign OUTPUT_LEVEL_SELECT_O      = output_mode[`ADCR_BIT_LEVEL_SEL];
    assign DATA_FORMAT_O              = output_mode[1:0];
    assign DRIVE_STRENGTH_HIGH_VOLT_O = output_drive[3:2];
    assign DRIVE_STRENGTH_LOW_VOLT_O  = output_drive[1:0];
    assign SAMPLE_CLOCK_OUT_INVERT_O  = out_clk_ctrl[`ADCR_BIT_CLK_INVERT];
    assign EXTERNAL_REF_SELECT_O      = ref_select[`ADCR_BIT_EXT_REF];
    assign OUTPUT_RATE_DIV_O          = output_rate[5:0];

endmodule

`default_nettype wire

// ### tb/adcr_reg_bank_checker.sv
/*
 * Port assertions for the register bank.
 * Assumes binding onto adcr_reg_bank; sees ports only.
 */
`timescale 1ns/1ps
`default_nettype none

module adcr_reg_bank_checker (
    input wire logic        REF_CLK_I,
    input wire logic        NRST_I,
    input wire logic        SCLK_I,
    input wire logic        SELECT_N_I,
    input wire logic        SDIO_O,
    input wire logic        SDIO_OE_N_O,
    input wire logic        SAMPLE_STB_I,
    input wire logic [15:0] DATA_O,
    input wire logic [15:0] DATA_OE_N_O,
    input wire logic        RANGE_FLAG_O,
    input wire logic [1:0]  POWER_STATE_SELECT_O,
    input wire logic        MULTIPLIER_LOOP_ON_O,
    input wire logic        AUTO_BAND_SELECT_O,
    input wire logic        EXTERNAL_REF_SELECT_O,
    input wire logic [5:0]  OUTPUT_RATE_DIV_O,
    input wire logic [1:0]  DRIVE_STRENGTH_LOW_VOLT_O
);
    logic [3:0]  idle_cnt;
    logic [26:0] cfg;

    // Settings that only a host frame may move
    assign cfg = {DATA_OE_N_O, POWER_STATE_SELECT_O, MULTIPLIER_LOOP_ON_O,
                  AUTO_BAND_SELECT_O, EXTERNAL_REF_SELECT_O, OUTPUT_RATE_DIV_O};

    // Cycles since the port was last selected, saturating
    always_ff @(posedge REF_CLK_I) begin
        if (!NRST_I || !SELECT_N_I) begin
            idle_cnt <= 4'h0;
        end else if (idle_cnt != 4'hf) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!NRST_I);

    // Port left deselected for a while
    sequence s_deselected;
        SELECT_N_I [*6];
    endsequence

    a_reset_defaults: assert property ($rose(NRST_I) |-> SDIO_OE_N_O && DATA_O == 16'h0000
        && !RANGE_FLAG_O && DATA_OE_N_O == 16'h0000 && POWER_STATE_SELECT_O == 2'h0
        && OUTPUT_RATE_DIV_O == 6'h00 && DRIVE_STRENGTH_LOW_VOLT_O == 2'h2)
        else $error("outputs not at defaults after reset");
    a_sdio_release: assert property (s_deselected |-> SDIO_OE_N_O)
        else $error("data line still driven after deselect");
    a_drive_in_frame: assert property ($fell(SDIO_OE_N_O) |-> !SELECT_N_I && !$past(SELECT_N_I, 8))
        else $error("data line driven outside a read frame");
    a_sdio_after_fall: assert property ($changed(SDIO_O) && !SDIO_OE_N_O && !SELECT_N_I
        |-> !$past(SCLK_I, 2) || !$past(SCLK_I, 3) || !$past(SCLK_I, 4)
        || !$past(SCLK_I, 5) || !$past(SCLK_I, 6))
        else $error("read bit changed away from a clock fall");
    a_data_hold: assert property (!SAMPLE_STB_I |=> $stable(DATA_O))
        else $error("data bus moved without a sample");
    a_flag_hold: assert property (!SAMPLE_STB_I |=> $stable(RANGE_FLAG_O))
        else $error("range flag moved without a sample");
    a_oe_uniform: assert property (DATA_OE_N_O == 16'h0000 || DATA_OE_N_O == 16'hffff)
        else $error("data enables split");
    a_cfg_by_host: assert property ($changed(cfg) |-> idle_cnt < 4'd10)
        else $error("setting changed with no frame");
endmodule

bind adcr_reg_bank adcr_reg_bank_checker u_chk (
    .REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I), .SCLK_I(SCLK_I), .SELECT_N_I(SELECT_N_I),
    .SDIO_O(SDIO_O), .SDIO_OE_N_O(SDIO_OE_N_O), .SAMPLE_STB_I(SAMPLE_STB_I),
    .DATA_O(DATA_O), .DATA_OE_N_O(DATA_OE_N_O), .RANGE_FLAG_O(RANGE_FLAG_O),
    .POWER_STATE_SELECT_O(POWER_STATE_SELECT_O), .MULTIPLIER_LOOP_ON_O(MULTIPLIER_LOOP_ON_O),
    .AUTO_BAND_SELECT_O(AUTO_BAND_SELECT_O), .EXTERNAL_REF_SELECT_O(EXTERNAL_REF_SELECT_O),
    .OUTPUT_RATE_DIV_O(OUTPUT_RATE_DIV_O),
    .DRIVE_STRENGTH_LOW_VOLT_O(DRIVE_STRENGTH_LOW_VOLT_O));

`default_nettype wire

// ### tb/adcr_host_model.sv
/*
 * Serial host model that frames register accesses.
 * Assumes the bench merges the data line drivers.
 */
`timescale 1ns/1ps
`default_nettype none

module adcr_host_model (
    output logic      sclk_o,
    output logic      select_n_o,
    output logic      sdio_o,
    input  wire logic sdio_i
);
    logic lsb_mode;

    // Idle: clock low and still, port deselected
    initial begin
        sclk_o = 1'b0;
        select_n_o = 1'b1;
        sdio_o = 1'b0;
        lsb_mode = 1'b0;
    end

    // One bit in 800 ns; read bits taken just before the next fall
    task automatic shift_bit(input logic rd, input logic b, output logic q);
        sdio_o = rd ? ~sdio_o : b; // Released line never keeps its value
        #400;
        sclk_o = 1'b1;
        #400;
        q = sdio_i;
        sclk_o = 1'b0;
    endtask

    task automatic xfer(input logic rd, input logic [12:0] a, input int n,
                        input logic [15:0] wd, output logic [15:0] rdat);
        logic [15:0] ins;
        logic        q;
        int          i;
        int          k;
        ins = {rd, 2'b00, a};
        rdat = 16'h0000;
        select_n_o = 1'b0;
        #400;
        for (i = 0; i < 16; i++) begin
            shift_bit(1'b0, ins[lsb_mode ? i : 15 - i], q);
        end
        for (i = 0; i < 8 * n; i++) begin
            k = lsb_mode ? 8 - 8 * (i / 8) + i % 8 : 15 - 8 * (i / 8) - i % 8;
            shift_bit(rd, wd[k], q);
            rdat[k] = q;
        end
        #400;
        select_n_o = 1'b1;
        #1200;
    endtask
endmodule

`default_nettype wire

// ### tb/tb_adcr_reg_bank.sv
/*
 * Self-checking bench for the register bank.
 * Assumes host model and checker compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_adcr_reg_bank;
    localparam logic [7:0] PID   = 8'h3c; // Arbitrary value
    localparam logic [1:0] GRADE = 2'h2;  // Arbitrary value
    localparam int         LIMIT = 40000;
    logic [12:0] ofs [14] = '{13'h000, 13'h001, 13'h002, 13'h008, 13'h009, 13'h00a, 13'h00f,
                              13'h014, 13'h015, 13'h016, 13'h018, 13'h101, 13'h111, 13'h003};
    logic [7:0]  dft [14] = '{8'h18, PID, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  msk [14] = '{8'h00, 8'h00, 8'h00, 8'h03, 8'h04, 8'h7f, 8'h60,
                              8'hb7, 8'h0f, 8'h80, 8'h40, 8'h3f, 8'hff, 8'h00};
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        lock = 1'b0;
    logic        frst = 1'b0;
    logic        stb = 1'b0;
    logic [15:0] cha = 16'h0000;
    logic [15:0] chb = 16'h0000;
    logic [31:0] seed = 32'h8842;
    logic [15:0] pa, pb, q;
    logic [7:0]  v;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cycles = 0;
    int          i, r;
    wire         sclk, sel_n, host_d, sdo, sdo_oe_n, sdi, rflag, ext_ref, auto_band, loop_on;
    wire [15:0]  dout, dout_oe_n;
    wire [1:0]   pwr;
    wire [5:0]   rate;

    // Data line level from both drivers
    assign sdi = !sdo_oe_n ? sdo : host_d;

    adcr_reg_bank #(.PART_ID(PID), .GRADE_ID(GRADE)) dut (
        .REF_CLK_I(clk), .NRST_I(nrst), .SCLK_I(sclk), .SELECT_N_I(sel_n), .SDIO_I(sdi),
        .SDIO_O(sdo), .SDIO_OE_N_O(sdo_oe_n), .LOCK_I(lock), .FILTER_RESET_I(frst),
        .CHAN_A_I(cha), .CHAN_B_I(chb), .SAMPLE_STB_I(stb), .DATA_O(dout),
        .DATA_OE_N_O(dout_oe_n), .RANGE_FLAG_O(rflag), .POWER_STATE_SELECT_O(pwr),
        .MULTIPLIER_LOOP_ON_O(loop_on), .AUTO_BAND_SELECT_O(auto_band),
        .MULTIPLIER_RATIO_O(), .BANDWIDTH_SELECT_O(), .OUTPUT_LEVEL_SELECT_O(),
        .DATA_FORMAT_O(), .DRIVE_STRENGTH_HIGH_VOLT_O(), .DRIVE_STRENGTH_LOW_VOLT_O(),
        .SAMPLE_CLOCK_OUT_INVERT_O(), .EXTERNAL_REF_SELECT_O(ext_ref),
        .OUTPUT_RATE_DIV_O(rate));

    adcr_host_model host (.sclk_o(sclk), .select_n_o(sel_n), .sdio_o(host_d), .sdio_i(sdi));

    // 10 MHz reference clock
    always #50 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            num_errors++;
            $display("MISMATCH at %0t: timeout", $time);
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] exp_of(input int k, input logic [7:0] d);
        return (dft[k] & ~msk[k]) | (d & msk[k]);
    endfunction

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: register got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_port(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: port got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apply_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        #33;
        host.xfer(1'b0, a, 1, {d, 8'h00}, q);
    endtask

    task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
        #33;
        host.xfer(1'b1, a, 1, 16'h0000, q);
        chk_reg(q[15:8], e);
    endtask

    task automatic strobe(input logic [15:0] a, input logic [15:0] b);
        @(posedge clk);
        cha <= a;
        chb <= b;
        stb <= 1'b1;
        @(posedge clk);
        stb <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        apply_reset();
        for (i = 0; i < 14; i++) rd_chk(ofs[i], dft[i]);
        for (r = 0; r < 2; r++) begin
            for (i = 1; i < 14; i++) begin
                seed = xs(seed);
                v = (r == 0) ? 8'hff : seed[7:0];
                wr(ofs[i], v);
                rd_chk(ofs[i], exp_of(i, v));
            end
        end
        for (i = 0; i < 4; i++) begin
            wr(13'h008, i[7:0]);
            chk_port({14'h0, pwr}, i[15:0]);
        end
        wr(13'h018, 8'h40);
        chk_port({15'h0, ext_ref}, 16'h0001);
        wr(13'h00a, 8'h40);
        chk_port({15'h0, auto_band}, 16'h0001);
        wr(13'h101, 8'h2a);
        chk_port({10'h0, rate}, 16'h002a);
        @(posedge clk) lock <= 1'b1;
        rd_chk(13'h00a, 8'hc0);
        wr(13'h00a, 8'h00);
        rd_chk(13'h00a, 8'h80);
        @(posedge clk) lock <= 1'b0;
        host.xfer(1'b0, 13'h016, 2, 16'h800c, q);
        host.xfer(1'b1, 13'h016, 2, 16'h0000, q);
        chk_port(q, 16'h800c);
        wr(13'h009, 8'h04);
        wr(13'h00a, 8'h45);
        wr(13'h00f, 8'h60);
        wr(13'h000, 8'h24);
        rd_chk(13'h00f, 8'h00);
        rd_chk(13'h015, 8'h02);
        rd_chk(13'h00a, 8'h45);
        rd_chk(13'h000, 8'h18);
        chk_port({15'h0, loop_on}, 16'h0001);
        wr(13'h000, 8'h42);
        host.lsb_mode = 1'b1;
        wr(13'h018, 8'h40);
        rd_chk(13'h018, 8'h40);
        rd_chk(13'h000, 8'h5a);
        apply_reset();
        host.lsb_mode = 1'b0;
        rd_chk(13'h000, 8'h18);
        rd_chk(13'h009, 8'h00);
        seed = xs(seed);
        pa = seed[15:0];
        pb = ~pa;
        wr(13'h014, 8'h04);
        strobe(pa, pa);
        chk_port(dout, ~pa);
        chk_port(dout_oe_n, 16'h0000);
        wr(13'h014, 8'h10);
        chk_port(dout_oe_n, 16'hffff);
        wr(13'h014, 8'h20);
        strobe(pa, pb);
        q = dout;
        strobe(pa, pb);
        chk_port(dout, (q === pa) ? pb : pa);
        chk_port(q ^ dout, pa ^ pb);
        wr(13'h014, 8'h00);
        wr(13'h111, 8'h90);
        strobe(16'h4001, 16'h4001);
        chk_port({15'h0, rflag}, 16'h0001);
        strobe(16'h4000, 16'h4000);
        chk_port({15'h0, rflag}, 16'h0000);
        @(posedge clk) frst <= 1'b1;
        repeat (4) @(posedge clk);
        strobe(16'h0100, 16'h0100);
        chk_port({15'h0, rflag}, 16'h0001);
        wr(13'h111, 8'h10);
        strobe(16'h0100, 16'h0100);
        chk_port({15'h0, rflag}, 16'h0000);
        @(posedge clk) frst <= 1'b0;
        end_of_test();
    end
endmodule

`default_nettype wire
